// ==== rtl/nbp_defs.vh ====
// Constants for the serial NAND block-protect and instruction framing block
`ifndef NBP_DEFS_VH
`define NBP_DEFS_VH

// Opcodes
`define NBP_OP_RESET 8'hff
`define NBP_OP_JEDEC_ID 8'h9f
`define NBP_OP_RD_SR_A 8'h0f
`define NBP_OP_RD_SR_B 8'h05
`define NBP_OP_WR_SR_A 8'h1f
`define NBP_OP_WR_SR_B 8'h01
`define NBP_OP_WR_EN 8'h06
`define NBP_OP_WR_DIS 8'h04
`define NBP_OP_BBM_SWAP 8'ha1
`define NBP_OP_RD_BBM 8'ha5
`define NBP_OP_ECC_PA 8'ha9
`define NBP_OP_ERASE 8'hd8
`define NBP_OP_LOAD 8'h02
`define NBP_OP_LOAD_RND 8'h84
`define NBP_OP_LOAD_Q 8'h32
`define NBP_OP_LOAD_RND_Q 8'h34
`define NBP_OP_PROG_EXEC 8'h10
`define NBP_OP_PAGE_READ 8'h13

// Page address fields
`define NBP_BLK_MSB 15
`define NBP_BLK_LSB 6

// Busy time of an internal operation in ns, and in 20 MHz cycles
`define NBP_BUSY_NS 500
`define NBP_CLK_NS 50
`define NBP_BUSY_CYC ((`NBP_BUSY_NS + `NBP_CLK_NS - 1) / `NBP_CLK_NS)

// Neutral identity values, arbitrary
`define NBP_MAKER_CODE 8'h5a
`define NBP_PART_CODE 16'h1234

`endif

// ==== rtl/nbp_core.v ====
// Block-protect decoder and serial instruction framing for a serial NAND device
`timescale 1ns/1ps
`include "nbp_defs.vh"

module nbp_core #(
    parameter BUSY_CYC = `NBP_BUSY_CYC
)(
    // Clock and reset
    input wire i_mclk,
    input wire i_rst,
    // Serial link
    input wire i_cs_n,
    input wire i_sclk,
    input wire i_serial_input_line,
    output reg o_so,
    output reg o_so_oe,
    // Protection configuration
    input wire i_top_bottom_select,
    input wire i_protect_code_bit3,
    input wire i_protect_code_bit2,
    input wire i_protect_code_bit1,
    input wire i_protect_code_bit0,
    // Status
    output reg o_busy,
    output reg o_wr_en_latch,
    output reg o_prog_fail,
    output reg o_erase_fail,
    // Completed commands toward array logic
    output reg o_cmd_valid,
    output reg [7:0] o_cmd_opcode,
    output reg [15:0] o_row_pointer
);

// ----------------------------------------
// Protection decode
// ----------------------------------------
function prot_hit;
    input tb;
    input [3:0] code;
    input [9:0] blk;
    reg [10:0] span;
    begin
        span = 11'h001 << code;
        if (code == 4'h0)
            prot_hit = 1'b0;
        else if (code[3:1] == 3'b101 || code[3:2] == 2'b11)
            prot_hit = 1'b1;
        else if (!tb)
            prot_hit = ({1'b0, blk} >= (11'h400 - span));
        else
            prot_hit = ({1'b0, blk} < span);
    end
endfunction

// ----------------------------------------
// Opcode classes
// ----------------------------------------
function is_status_read;
    input [7:0] op;
    begin
        is_status_read = (op == `NBP_OP_RD_SR_A) || (op == `NBP_OP_RD_SR_B);
    end
endfunction

function is_busy_safe;
    input [7:0] op;
    begin
        // Only ID and status reads get through while busy
        is_busy_safe = (op == `NBP_OP_JEDEC_ID) || is_status_read(op);
    end
endfunction

function is_write_op;
    input [7:0] op;
    begin
        case (op)
            `NBP_OP_WR_SR_A, `NBP_OP_WR_SR_B, `NBP_OP_WR_EN, `NBP_OP_WR_DIS:
                is_write_op = 1'b1;
            `NBP_OP_BBM_SWAP, `NBP_OP_ERASE, `NBP_OP_PROG_EXEC, `NBP_OP_PAGE_READ:
                is_write_op = 1'b1;
            `NBP_OP_LOAD, `NBP_OP_LOAD_RND, `NBP_OP_LOAD_Q, `NBP_OP_LOAD_RND_Q:
                is_write_op = 1'b1;
            `NBP_OP_RESET:
                is_write_op = 1'b1;
            default:
                is_write_op = 1'b0;
        endcase
    end
endfunction

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
// Link clock must stay level for more than 1 cycle, else edges are lost
reg [2:0] cs_s_q;
reg [2:0] ck_s_q;
reg [1:0] di_s_q;
always @(posedge i_mclk)
begin
    if (i_rst)
    begin
        cs_s_q <= 3'h7;
        ck_s_q <= 3'h0;
        di_s_q <= 2'h0;
    end
    else
    begin
        cs_s_q <= {cs_s_q[1:0], i_cs_n};
        ck_s_q <= {ck_s_q[1:0], i_sclk};
        di_s_q <= {di_s_q[0], i_serial_input_line};
    end
end

wire cs_n = cs_s_q[1];
wire cs_fall = cs_s_q[2] & ~cs_s_q[1];
wire cs_rise = ~cs_s_q[2] & cs_s_q[1];
wire ck_rise = ~ck_s_q[2] & ck_s_q[1] & ~cs_n;
wire ck_fall = ck_s_q[2] & ~ck_s_q[1] & ~cs_n;

// ----------------------------------------
// Frame shifter
// ----------------------------------------
reg [7:0] shift_q;
reg [2:0] bit_q;
reg [3:0] byte_q;
reg [7:0] op_q;
reg [15:0] pa_q;
reg [7:0] sr_q;
reg [31:0] tx_q;
reg busy_frame_q;
reg [15:0] busy_cnt_q;
reg [7:0] in_byte;
reg is_wr;
reg allowed;

always @*
begin
    in_byte = {shift_q[6:0], di_s_q[1]};
    is_wr = is_write_op(op_q);
    allowed = !busy_frame_q || is_busy_safe(op_q);
end

always @(posedge i_mclk)
begin
    if (i_rst)
    begin
        shift_q <= 8'h00;
        bit_q <= 3'h0;
        byte_q <= 4'h0;
        op_q <= 8'h00;
        pa_q <= 16'h0000;
        sr_q <= 8'h00;
        tx_q <= 32'h0;
        busy_frame_q <= 1'b0;
        o_so <= 1'b0;
        o_so_oe <= 1'b0;
    end
    else if (cs_fall)
    begin
        // New frame; busy is frozen so the frame is judged as a whole
        shift_q <= 8'h00;
        bit_q <= 3'h0;
        byte_q <= 4'h0;
        op_q <= 8'h00;
        busy_frame_q <= o_busy;
    end
    else if (cs_rise)
        o_so_oe <= 1'b0;
    else if (ck_rise)
    begin
        shift_q <= in_byte;
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7)
        begin
            if (byte_q != 4'hf)
                byte_q <= byte_q + 4'h1;
            if (byte_q == 4'h0)
            begin
                op_q <= in_byte;
                if (in_byte == `NBP_OP_JEDEC_ID)
                    tx_q <= {8'h00, `NBP_MAKER_CODE, `NBP_PART_CODE};
            end
            else if (byte_q == 4'h1 && is_status_read(op_q))
                tx_q <= {4{o_busy ? 8'h01 : 8'h00}};
            else if (byte_q == 4'h2)
                pa_q[15:8] <= in_byte;
            else if (byte_q == 4'h3)
                pa_q[7:0] <= in_byte;
        end
    end
    else if (ck_fall && byte_q != 4'h0 && is_busy_safe(op_q))
    begin
        // Write frames leave the output line undriven
        o_so_oe <= 1'b1;
        o_so <= tx_q[31];
        tx_q <= {tx_q[30:0], tx_q[31]};
    end
end

// ----------------------------------------
// Completion and busy
// ----------------------------------------
reg whole_bytes;
reg needs_pa;
reg blocked;
always @*
begin
    whole_bytes = (bit_q == 3'h0) && (byte_q != 4'h0);
    needs_pa = (op_q == `NBP_OP_ERASE) || (op_q == `NBP_OP_PROG_EXEC);
    blocked = needs_pa && prot_hit(i_top_bottom_select,
        {i_protect_code_bit3, i_protect_code_bit2, i_protect_code_bit1,
        i_protect_code_bit0}, pa_q[`NBP_BLK_MSB:`NBP_BLK_LSB]);
end

always @(posedge i_mclk)
begin
    if (i_rst)
    begin
        o_busy <= 1'b0;
        busy_cnt_q <= 16'h0000;
        o_wr_en_latch <= 1'b0;
        o_prog_fail <= 1'b0;
        o_erase_fail <= 1'b0;
        o_cmd_valid <= 1'b0;
        o_cmd_opcode <= 8'h00;
        o_row_pointer <= 16'h0000;
    end
    else
    begin
        o_cmd_valid <= 1'b0;
        // Counter is 16 bits wide, so BUSY_CYC above 65535 wraps
        if (o_busy)
        begin
            if (busy_cnt_q <= 16'h0001)
                o_busy <= 1'b0;
            busy_cnt_q <= busy_cnt_q - 16'h0001;
        end
        // Reads other than page read end anywhere and touch nothing
        if (cs_rise && is_wr && whole_bytes && allowed)
        begin
            if (op_q == `NBP_OP_WR_EN)
                o_wr_en_latch <= 1'b1;
            else if (op_q == `NBP_OP_WR_DIS)
                o_wr_en_latch <= 1'b0;
            else if (needs_pa)
            begin
                o_prog_fail <= (op_q == `NBP_OP_PROG_EXEC) &&
                    (blocked || !o_wr_en_latch);
                o_erase_fail <= (op_q == `NBP_OP_ERASE) &&
                    (blocked || !o_wr_en_latch);
                o_wr_en_latch <= 1'b0;
                if (!blocked && o_wr_en_latch)
                begin
                    o_cmd_valid <= 1'b1;
                    o_cmd_opcode <= op_q;
                    o_row_pointer <= pa_q;
                    o_busy <= 1'b1;
                    busy_cnt_q <= BUSY_CYC[15:0];
                end
            end
            else
            begin
                o_cmd_valid <= 1'b1;
                o_cmd_opcode <= op_q;
                o_row_pointer <= pa_q;
                if (op_q == `NBP_OP_PAGE_READ || op_q == `NBP_OP_BBM_SWAP)
                begin
                    o_busy <= 1'b1;
                    busy_cnt_q <= BUSY_CYC[15:0];
                end
                if (op_q == `NBP_OP_PAGE_READ)
                    o_wr_en_latch <= 1'b0;
                if (op_q == `NBP_OP_RESET)
                begin
                    // Reset also clears both fail bits
                    o_prog_fail <= 1'b0;
                    o_erase_fail <= 1'b0;
                end
            end
        end
    end
end

endmodule // nbp_core

// ==== tb/nbp_host.sv ====
// Host controller model driving the serial link
`timescale 1ns/1ps
module nbp_host (
    input wire i_mclk,
    input wire i_so,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_si
);
    logic [31:0] rx;
    initial
    begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_si = 1'b0;
        rx = '0;
    end
    task automatic frame(input logic [39:0] d, input int n);
        int i;
        @(posedge i_mclk) o_cs_n <= 1'b0;
        repeat (4) @(posedge i_mclk);
        for (i = n - 1; i >= 0; i--)
        begin
            o_si <= d[i];
            repeat (4) @(posedge i_mclk);
            o_sclk <= 1'b1;
            rx <= {rx[30:0], i_so};
            repeat (4) @(posedge i_mclk);
            o_sclk <= 1'b0;
        end
        repeat (4) @(posedge i_mclk);
        o_cs_n <= 1'b1;
        // Released line shows the inverse, not a held value
        o_si <= ~o_si;
        repeat (8) @(posedge i_mclk);
    endtask
endmodule // nbp_host

// ==== tb/nbp_core_props.sv ====
// Port assertions for the block-protect and framing core
`timescale 1ns/1ps
module nbp_core_props #(
    parameter BUSY_CYC = 10
)(
    input wire i_mclk, i_rst, i_cs_n, i_sclk, i_serial_input_line, o_so, o_so_oe,
    input wire i_top_bottom_select, i_protect_code_bit3, i_protect_code_bit2,
    input wire i_protect_code_bit1, i_protect_code_bit0, o_busy, o_wr_en_latch,
    input wire o_prog_fail, o_erase_fail, o_cmd_valid,
    input wire [7:0] o_cmd_opcode,
    input wire [15:0] o_row_pointer
);
    localparam int BMAX = 400;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    wire [3:0] code = {i_protect_code_bit3, i_protect_code_bit2,
        i_protect_code_bit1, i_protect_code_bit0};
    wire pe = o_cmd_opcode == 8'hd8 || o_cmd_opcode == 8'h10;
    function automatic logic hit(input logic t, input logic [3:0] c, input logic [9:0] b);
        int span;
        span = 1 << c;
        if (c == 4'h0) hit = 1'b0;
        else if (c[3] && (c[2] || c[1])) hit = 1'b1;
        else if (t) hit = b < span;
        else hit = b >= 1024 - span;
    endfunction
    chk_valid_pulse: assert property (o_cmd_valid |=> !o_cmd_valid)
        else $error("command valid held too long");
    chk_prot_range: assert property (o_cmd_valid && pe
        |-> !hit(i_top_bottom_select, code, o_row_pointer[15:6]))
        else $error("protected block accepted");
    chk_busy_start: assert property (o_cmd_valid && pe |-> ##[0:1] o_busy)
        else $error("busy missing after accepted command");
    chk_busy_end: assert property ($rose(o_busy) |-> ##[1:BMAX] !o_busy)
        else $error("busy never cleared");
    chk_cs_done: assert property (o_cmd_valid |-> i_cs_n)
        else $error("command accepted with select low");
    chk_read_quiet: assert property (o_cmd_valid |-> !(o_cmd_opcode inside {8'h9f, 8'h0f, 8'h05}))
        else $error("read produced a command");
    chk_oe_release: assert property ($rose(i_cs_n) |-> ##[1:6] !o_so_oe)
        else $error("output enable kept after select rise");
    chk_busy_refuse: assert property (o_cmd_valid |-> !$past(o_busy))
        else $error("command accepted while busy");
    cover property (o_cmd_valid && pe);
    cover property ($fell(o_busy));
    cover property (o_so_oe && o_busy);
endmodule // nbp_core_props

// ==== tb/tb.sv ====
// Self-checking bench for the block-protect and framing core
`timescale 1ns/1ps
`include "nbp_defs.vh"
module tb;
    localparam int BC = 300;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic tsel = 1'b0;
    logic [3:0] pc = 4'h0;
    wire cs_n, sclk, si, so, so_oe, busy, wel, pf, ef, cv;
    wire [7:0] op;
    wire [15:0] rp;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #25 i_mclk = ~i_mclk;
    nbp_host nbp_host_inst (.i_mclk(i_mclk), .i_so(so), .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si));
    nbp_core #(.BUSY_CYC(BC)) nbp_core_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_serial_input_line(si), .o_so(so), .o_so_oe(so_oe),
        .i_top_bottom_select(tsel), .i_protect_code_bit3(pc[3]), .i_protect_code_bit2(pc[2]),
        .i_protect_code_bit1(pc[1]), .i_protect_code_bit0(pc[0]), .o_busy(busy),
        .o_wr_en_latch(wel), .o_prog_fail(pf), .o_erase_fail(ef), .o_cmd_valid(cv),
        .o_cmd_opcode(op), .o_row_pointer(rp));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic idle;
        while (busy !== 1'b0 && cyc < 30000) @(posedge i_mclk);
    endtask
    task automatic erase(input logic t, input logic [3:0] c, input logic [9:0] b, input logic ok);
        tsel <= t;
        pc <= c;
        nbp_host_inst.frame(40'h06, 8);
        nbp_host_inst.frame({8'hd8, 8'h00, b, 6'h00}, 32);
        chk(busy, ok);
        chk(ef, !ok);
        if (ok) chk(rp, {b, 6'h00});
        if (ok) chk(op, 8'hd8);
        idle();
    endtask
    always @(posedge i_mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_mismatch++;
            summarize();
        end
    end
    initial
    begin
        repeat (8) @(posedge i_mclk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_mclk);
        erase(1'b1, 4'h0, 10'd0, 1'b1);
        erase(1'b0, 4'h1, 10'd1021, 1'b1);
        erase(1'b0, 4'h1, 10'd1022, 1'b0);
        erase(1'b0, 4'h9, 10'd511, 1'b1);
        erase(1'b0, 4'h9, 10'd512, 1'b0);
        erase(1'b1, 4'h1, 10'd2, 1'b1);
        erase(1'b1, 4'h1, 10'd1, 1'b0);
        erase(1'b1, 4'h9, 10'd512, 1'b1);
        erase(1'b1, 4'h9, 10'd511, 1'b0);
        erase(1'b1, 4'ha, 10'd700, 1'b0);
        erase(1'b0, 4'hc, 10'd5, 1'b0);
        tsel <= 1'b1;
        pc <= 4'h1;
        nbp_host_inst.frame(40'h06, 8);
        nbp_host_inst.frame({8'h10, 8'h00, 10'd1, 6'h00}, 32);
        chk({busy, pf}, 2'b01);
        pc <= 4'h0;
        nbp_host_inst.frame(40'h06, 8);
        nbp_host_inst.frame({8'h10, 8'h00, 10'd1, 6'h00}, 32);
        chk({busy, pf, op}, {2'b10, 8'h10});
        idle();
        nbp_host_inst.frame(40'h06, 8);
        nbp_host_inst.frame({8'hd8, 24'h000240}, 32);
        nbp_host_inst.frame(40'h06, 8);
        chk(wel, 1'b0);
        nbp_host_inst.frame({8'h9f, 32'h0}, 40);
        chk(nbp_host_inst.rx, {8'h00, `NBP_MAKER_CODE, `NBP_PART_CODE});
        chk(so_oe, 1'b0);
        idle();
        chk(busy, 1'b0);
        nbp_host_inst.frame(40'h06, 8);
        nbp_host_inst.frame(40'h01, 5);
        nbp_host_inst.frame({8'hd8, 24'h000240} >> 1, 31);
        chk({busy, wel}, 2'b01);
        summarize();
    end
endmodule // tb
bind nbp_core nbp_core_props #(.BUSY_CYC(BUSY_CYC)) nbp_core_props_inst (.*);
